/* inc/lcd_link_pkg.sv */
// Shared constants, types and decode helper for the LCD host data port
package lcd_link_pkg;

  // Bus mode straps
  localparam logic [1:0] MODE_M68 = 2'h0;
  localparam logic [1:0] MODE_I80 = 2'h1;
  localparam logic [1:0] MODE_SER = 2'h2;

  // Command patterns, compared under a mask
  localparam logic [7:0] CMD_MASK_B0 = 8'hfe;
  localparam logic [7:0] CMD_OSC_SRC = 8'h7a;
  localparam logic [7:0] CMD_OSC_EN = 8'h7e;
  localparam logic [7:0] CMD_COL_MSB = 8'h26;
  localparam logic [7:0] CMD_CLR_RAM = 8'h36;
  localparam int COL_CMD_BIT = 7;

  // Column pointer and power-on values
  localparam logic [7:0] COL_LAST = 8'hff;
  localparam logic [7:0] COL_RST = 8'h00;
  localparam logic OSC_EXT_RST = 1'b0;
  localparam logic OSC_EN_RST = 1'b0;
  localparam logic [2:0] SER_LAST_BIT = 3'h7;

  // Controller register map and fields
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_TX = 8'h04;
  localparam logic [7:0] REG_RX = 8'h08;
  localparam logic [7:0] REG_STAT = 8'h0c;
  localparam int CTRL_DC_BIT = 2;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_REF_BIT = 1;
  localparam int STAT_RDATA_LSB = 8;
  localparam logic [1:0] CTRL_MODE_RST = 2'h0;

  // Pin phase length seen by the slow link-side sampler
  localparam int MCLK_NS = 5;
  localparam int PHASE_NS = 320;
  localparam int PHASE_CYC = (PHASE_NS + MCLK_NS - 1) / MCLK_NS;
  localparam logic [6:0] PHASE_LAST = 7'(PHASE_CYC - 1);

  typedef enum logic [2:0] {
    H_IDLE, H_SETUP, H_ACTIVE, H_HOLD, H_SHI, H_SLO
  } host_state_t;

  // Masked command match
  function automatic logic cmdHit(input logic [7:0] b, input logic [7:0] pat);
    cmdHit = ((b & CMD_MASK_B0) == pat);
  endfunction

endpackage

/* inc/lcd_link_if.sv */
// Pin bundle between the LCD host controller and the LCD data port
interface lcd_link_if;
  logic [1:0] busMode;
  logic csN;
  logic dc;
  logic dirRd;
  logic xferClk;
  logic sdata;
  logic [7:0] hostData;
  logic hostOe;
  logic [7:0] devData;
  logic devOe;
  logic [7:0] data;

  // Shared data wire; undriven bus reads as pulled high
  assign data = hostOe ? hostData : (devOe ? devData : 8'hff);

  modport dev (
    input busMode, csN, dc, dirRd, xferClk, sdata, data,
    output devData, devOe
  );

  modport host (
    output busMode, csN, dc, dirRd, xferClk, sdata, hostData, hostOe,
    input data
  );
endinterface

/* src/lcd_port_device.sv */
// LCD data port: pin sampling, command decode and column pointer
// Behaviour
// - Source command bit0 selects internal/external oscillator
// - Enable command bit0 switches oscillator master
// - Host sends enable only after source select
// - Column command loads seven low pointer bits
// - 6800 read: data out, then pointer increments
// - 6800 write: capture at enable fall, increment
// - 8080 read: valid at read rise, increment
// - 8080 write: capture at write rise, increment
// - Serial write: sample falling clock, increment per byte
// - Serial link never reads display RAM
// - Dummy write after clear keeps pointer
// - Pointer wraps on overflow of last column
// - Of the commands, only the two column commands move the column pointer
module lcd_port_device import lcd_link_pkg::*; (
  // Link clock and reset
  input wire logic linkClk,
  input wire logic rst_n,
  // Host pins
  lcd_link_if.dev link,
  // Display RAM side
  output logic ramWe,
  output logic [7:0] ramAddr,
  output logic [7:0] ramWrData,
  input wire logic [7:0] ramRdData,
  // Decoded command stream
  output logic cmdValid,
  output logic [7:0] cmdByte,
  // Oscillator control: external source select and enable
  output logic oscExtSel,
  output logic oscEnable
);

  localparam int SYNC_W = 15;
  // Idle pin levels: deselected, read strobe high, bus pulled high
  localparam logic [SYNC_W-1:0] SYNC_IDLE = {2'h0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 8'hff};

  logic [SYNC_W-1:0] pinRaw;
  logic [SYNC_W-1:0] sync1_ff;
  logic [SYNC_W-1:0] sync2_ff;
  logic [1:0] modeS;
  logic csS;
  logic dcS;
  logic rdS;
  logic clkS;
  logic sdS;
  logic [7:0] dataS;
  logic prevClk_ff;
  logic prevRd_ff;
  logic clkFall;
  logic clkRise;
  logic rdRise;
  logic byteEv;
  logic rdAct;
  logic rdEnd;
  logic [7:0] byteVal;

  logic [7:0] col_ff, nxt_col;
  logic clrPend_ff, nxt_clrPend;
  logic oscExt_ff, nxt_oscExt;
  logic oscEn_ff, nxt_oscEn;
  logic [2:0] bitCnt_ff, nxt_bitCnt;
  logic [6:0] shift_ff, nxt_shift;
  logic [7:0] rdData_ff, nxt_rdData;
  logic ramWe_ff, nxt_ramWe;
  logic [7:0] ramAddr_ff, nxt_ramAddr;
  logic [7:0] wrData_ff, nxt_wrData;
  logic cmdValid_ff, nxt_cmdValid;
  logic [7:0] cmdByte_ff, nxt_cmdByte;
  logic devOe_ff, nxt_devOe;

  // Pointer step with wrap; no page change on overflow
  function automatic logic [7:0] colStep(input logic [7:0] c);
    colStep = (c == COL_LAST) ? COL_RST : 8'(c + 8'h01);
  endfunction

  // Host pins come from another clock domain
  assign pinRaw = {link.busMode, link.csN, link.dc, link.dirRd,
                   link.xferClk, link.sdata, link.data};

  // Two-stage synchroniser, first stage feeds only the second
  always_ff @(posedge linkClk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_ff <= SYNC_IDLE;
      sync2_ff <= SYNC_IDLE;
      prevClk_ff <= 1'b0;
      prevRd_ff <= 1'b1;
    end else begin
      sync1_ff <= pinRaw;
      sync2_ff <= sync1_ff;
      prevClk_ff <= clkS;
      prevRd_ff <= rdS;
    end
  end

  // Unpack synchronised pins
  assign {modeS, csS, dcS, rdS, clkS, sdS, dataS} = sync2_ff;
  assign clkFall = prevClk_ff & ~clkS;
  assign clkRise = ~prevClk_ff & clkS;
  assign rdRise = ~prevRd_ff & rdS;

  // Transfer events per bus mode
  always_comb begin
    byteEv = 1'b0;
    rdAct = 1'b0;
    rdEnd = 1'b0;
    byteVal = dataS;
    case (modeS)
      MODE_M68: begin
        byteEv = ~csS & clkFall & ~rdS;
        rdAct = ~csS & clkS & rdS;
        rdEnd = ~csS & clkFall & rdS;
      end
      MODE_I80: begin
        byteEv = ~csS & clkRise & rdS;
        rdAct = ~csS & ~rdS;
        rdEnd = ~csS & rdRise;
      end
      default: begin
        byteEv = ~csS & clkFall & (bitCnt_ff == SER_LAST_BIT);
        byteVal = {shift_ff, sdS};
        rdAct = 1'b0;
        rdEnd = 1'b0;
      end
    endcase
  end

  // Next state of pointer, decode and RAM side
  always_comb begin
    nxt_col = col_ff;
    nxt_clrPend = clrPend_ff;
    nxt_oscExt = oscExt_ff;
    nxt_oscEn = oscEn_ff;
    nxt_bitCnt = bitCnt_ff;
    nxt_shift = shift_ff;
    nxt_rdData = rdData_ff;
    nxt_ramWe = 1'b0;
    nxt_wrData = wrData_ff;
    nxt_cmdValid = 1'b0;
    nxt_cmdByte = cmdByte_ff;
    // Serial shifter; deselect restarts the byte
    if (csS || modeS != MODE_SER) begin
      nxt_bitCnt = 3'h0;
    end else if (clkFall) begin
      nxt_shift = {shift_ff[5:0], sdS};
      nxt_bitCnt = 3'(bitCnt_ff + 3'h1);
    end
    if (byteEv && dcS) begin
      nxt_ramWe = 1'b1;
      nxt_wrData = byteVal;
      if (clrPend_ff) begin
        nxt_clrPend = 1'b0;
      end else begin
        nxt_col = colStep(col_ff);
      end
    end else if (byteEv) begin
      nxt_cmdValid = 1'b1;
      nxt_cmdByte = byteVal;
      if (byteVal[COL_CMD_BIT]) begin
        nxt_col = {col_ff[7], byteVal[6:0]};
      end else if (cmdHit(byteVal, CMD_OSC_SRC)) begin
        nxt_oscExt = byteVal[0];
      end else if (cmdHit(byteVal, CMD_OSC_EN)) begin
        nxt_oscEn = byteVal[0];
      end else if (cmdHit(byteVal, CMD_COL_MSB)) begin
        nxt_col = {byteVal[0], col_ff[6:0]};
      end else if (cmdHit(byteVal, CMD_CLR_RAM)) begin
        nxt_clrPend = 1'b1;
      end
    end
    if (rdEnd && dcS) begin
      nxt_col = colStep(col_ff);
    end
    // Write uses the old pointer; otherwise prefetch at the pointer
    nxt_ramAddr = (byteEv && dcS) ? col_ff : nxt_col;
    // Read data is frozen while the host reads it
    if (!rdAct) begin
      nxt_rdData = ramRdData;
    end
    // Status reads (command select low) are not driven
    nxt_devOe = rdAct & dcS;
  end

  // State registers
  always_ff @(posedge linkClk or negedge rst_n) begin
    if (!rst_n) begin
      col_ff <= COL_RST;
      clrPend_ff <= 1'b0;
      oscExt_ff <= OSC_EXT_RST;
      oscEn_ff <= OSC_EN_RST;
      bitCnt_ff <= 3'h0;
      shift_ff <= 7'h00;
      rdData_ff <= 8'h00;
      ramWe_ff <= 1'b0;
      ramAddr_ff <= COL_RST;
      wrData_ff <= 8'h00;
      cmdValid_ff <= 1'b0;
      cmdByte_ff <= 8'h00;
      devOe_ff <= 1'b0;
    end else begin
      col_ff <= nxt_col;
      clrPend_ff <= nxt_clrPend;
      oscExt_ff <= nxt_oscExt;
      oscEn_ff <= nxt_oscEn;
      bitCnt_ff <= nxt_bitCnt;
      shift_ff <= nxt_shift;
      rdData_ff <= nxt_rdData;
      ramWe_ff <= nxt_ramWe;
      ramAddr_ff <= nxt_ramAddr;
      wrData_ff <= nxt_wrData;
      cmdValid_ff <= nxt_cmdValid;
      cmdByte_ff <= nxt_cmdByte;
      devOe_ff <= nxt_devOe;
    end
  end

  // Outputs straight from flops
  assign ramWe = ramWe_ff;
  assign ramAddr = ramAddr_ff;
  assign ramWrData = wrData_ff;
  assign cmdValid = cmdValid_ff;
  assign cmdByte = cmdByte_ff;
  assign oscExtSel = oscExt_ff;
  assign oscEnable = oscEn_ff;
  assign link.devData = rdData_ff;
  assign link.devOe = devOe_ff;

endmodule

/* src/lcd_port_host.sv */
// LCD host controller: register port and pin sequencer
//
// Chosen here: the address-and-strobe port and the address map.
module lcd_port_host import lcd_link_pkg::*; (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Register port
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [31:0] regRdData,
  // Link pins
  lcd_link_if.host link
);

  host_state_t st_ff, nxt_st;
  logic [6:0] cnt_ff, nxt_cnt;
  logic [2:0] bitIdx_ff, nxt_bitIdx;
  logic [1:0] mode_ff, nxt_mode;
  logic dcCfg_ff, nxt_dcCfg;
  logic [7:0] tx_ff, nxt_tx;
  logic isRd_ff, nxt_isRd;
  logic [7:0] rx_ff, nxt_rx;
  logic refused_ff, nxt_refused;
  logic srcSent_ff, nxt_srcSent;
  logic csN_ff, nxt_csN;
  logic dc_ff, nxt_dc;
  logic dirRd_ff, nxt_dirRd;
  logic clk_ff, nxt_clk;
  logic sd_ff, nxt_sd;
  logic oe_ff, nxt_oe;
  logic [31:0] rdData_ff, nxt_rdData;
  logic [7:0] din1_ff;
  logic [7:0] din2_ff;
  logic idle;
  logic phaseDone;
  logic startWr;
  logic startRd;

  assign idle = (st_ff == H_IDLE);
  assign phaseDone = (cnt_ff == PHASE_LAST);
  assign startWr = regWr && regAddr == REG_TX && idle;
  assign startRd = regWr && regAddr == REG_RX && idle && mode_ff != MODE_SER;

  // Register access and pin sequencing
  always_comb begin
    nxt_st = st_ff;
    nxt_cnt = idle ? 7'h00 : 7'(cnt_ff + 7'h01);
    nxt_bitIdx = bitIdx_ff;
    nxt_mode = mode_ff;
    nxt_dcCfg = dcCfg_ff;
    nxt_tx = tx_ff;
    nxt_isRd = isRd_ff;
    nxt_rx = rx_ff;
    nxt_refused = refused_ff;
    nxt_srcSent = srcSent_ff;
    nxt_csN = csN_ff;
    nxt_dc = dc_ff;
    nxt_dirRd = dirRd_ff;
    nxt_clk = clk_ff;
    nxt_sd = sd_ff;
    nxt_oe = oe_ff;
    nxt_rdData = 32'h0000_0000;
    // Read data stands one cycle after the strobe
    if (regRd) begin
      case (regAddr)
        REG_CTRL: nxt_rdData = {29'h0, dcCfg_ff, mode_ff};
        REG_STAT: nxt_rdData = {16'h0, rx_ff, 6'h0, refused_ff, ~idle};
        default: nxt_rdData = 32'h0000_0000;
      endcase
      if (regAddr == REG_STAT) begin
        nxt_refused = 1'b0;
      end
    end
    // Mode may change only between transfers
    if (regWr && regAddr == REG_CTRL && idle) begin
      nxt_mode = regWrData[1:0];
      nxt_dcCfg = regWrData[CTRL_DC_BIT];
      nxt_clk = (regWrData[1:0] == MODE_I80);
      // Stay busy one phase so a new strobe idle level is not seen with select
      nxt_st = H_HOLD;
      nxt_cnt = 7'h00;
    end
    if (startWr || startRd) begin
      nxt_tx = regWrData[7:0];
      nxt_isRd = startRd;
      nxt_csN = 1'b0;
      nxt_dc = dcCfg_ff;
      // 6800 read/write select high for reads, 8080 read strobe idle high
      nxt_dirRd = (mode_ff == MODE_M68) ? startRd : 1'b1;
      nxt_oe = startWr && mode_ff != MODE_SER;
      nxt_sd = regWrData[7];
      nxt_bitIdx = SER_LAST_BIT;
      nxt_st = H_SETUP;
      nxt_cnt = 7'h00;
      if (startWr && !dcCfg_ff) begin
        if (cmdHit(regWrData[7:0], CMD_OSC_SRC)) begin
          nxt_srcSent = 1'b1;
        end
        if (cmdHit(regWrData[7:0], CMD_OSC_EN) && !srcSent_ff) begin
          nxt_refused = 1'b1;
          nxt_csN = 1'b1;
          nxt_oe = 1'b0;
          nxt_st = H_IDLE;
        end
      end
    end
    if (phaseDone) begin
      nxt_cnt = 7'h00;
      case (st_ff)
        H_SETUP: begin
          if (mode_ff == MODE_SER) begin
            nxt_clk = 1'b1;
            nxt_st = H_SHI;
          end else begin
            nxt_st = H_ACTIVE;
            if (mode_ff == MODE_M68) begin
              nxt_clk = 1'b1;
            end else if (isRd_ff) begin
              nxt_dirRd = 1'b0;
            end else begin
              nxt_clk = 1'b0;
            end
          end
        end
        H_ACTIVE: begin
          if (isRd_ff) begin
            nxt_rx = din2_ff;
          end
          nxt_clk = (mode_ff == MODE_I80);
          nxt_dirRd = (mode_ff == MODE_M68) ? isRd_ff : 1'b1;
          nxt_st = H_HOLD;
        end
        H_SHI: begin
          nxt_clk = 1'b0;
          nxt_st = H_SLO;
        end
        H_SLO: begin
          if (bitIdx_ff == 3'h0) begin
            nxt_st = H_HOLD;
          end else begin
            nxt_bitIdx = 3'(bitIdx_ff - 3'h1);
            nxt_sd = tx_ff[3'(bitIdx_ff - 3'h1)];
            nxt_clk = 1'b1;
            nxt_st = H_SHI;
          end
        end
        H_HOLD: begin
          nxt_csN = 1'b1;
          nxt_oe = 1'b0;
          nxt_dirRd = 1'b1;
          nxt_st = H_IDLE;
        end
        default: nxt_st = H_IDLE;
      endcase
    end
  end

  // Registers; the bus data passes two flops before use
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff <= H_IDLE;
      cnt_ff <= 7'h00;
      bitIdx_ff <= 3'h0;
      mode_ff <= CTRL_MODE_RST;
      dcCfg_ff <= 1'b0;
      tx_ff <= 8'h00;
      isRd_ff <= 1'b0;
      rx_ff <= 8'h00;
      refused_ff <= 1'b0;
      srcSent_ff <= 1'b0;
      csN_ff <= 1'b1;
      dc_ff <= 1'b0;
      dirRd_ff <= 1'b1;
      clk_ff <= 1'b0;
      sd_ff <= 1'b0;
      oe_ff <= 1'b0;
      rdData_ff <= 32'h0000_0000;
      din1_ff <= 8'h00;
      din2_ff <= 8'h00;
    end else begin
      st_ff <= nxt_st;
      cnt_ff <= nxt_cnt;
      bitIdx_ff <= nxt_bitIdx;
      mode_ff <= nxt_mode;
      dcCfg_ff <= nxt_dcCfg;
      tx_ff <= nxt_tx;
      isRd_ff <= nxt_isRd;
      rx_ff <= nxt_rx;
      refused_ff <= nxt_refused;
      srcSent_ff <= nxt_srcSent;
      csN_ff <= nxt_csN;
      dc_ff <= nxt_dc;
      dirRd_ff <= nxt_dirRd;
      clk_ff <= nxt_clk;
      sd_ff <= nxt_sd;
      oe_ff <= nxt_oe;
      rdData_ff <= nxt_rdData;
      din1_ff <= link.data;
      din2_ff <= din1_ff;
    end
  end

  // Pin and port outputs from flops
  assign regRdData = rdData_ff;
  assign link.busMode = mode_ff;
  assign link.csN = csN_ff;
  assign link.dc = dc_ff;
  assign link.dirRd = dirRd_ff;
  assign link.xferClk = clk_ff;
  assign link.sdata = sd_ff;
  assign link.hostData = tx_ff;
  assign link.hostOe = oe_ff;

endmodule

/* testbench/lcd_link_props.sv */
// Concurrent checks on the pins between LCD host controller and data port
module lcd_link_props import lcd_link_pkg::*; (
  // Link clock and reset
  input wire logic linkClk,
  input wire logic rst_n,
  // Link pins
  input wire logic [1:0] busMode,
  input wire logic csN,
  input wire logic dc,
  input wire logic dirRd,
  input wire logic xferClk,
  input wire logic sdata,
  input wire logic [7:0] hostData,
  input wire logic hostOe,
  input wire logic devOe
);
  timeunit 1ns;
  timeprecision 1ps;
  // Pins are sampled on the slow clock; host phases span many of its cycles
  default clocking cb @(posedge linkClk); endclocking
  default disable iff (!rst_n);

  property p_ser_no_drive; busMode[1] |-> !devOe; endproperty
  a_ser_no_drive: assert property (p_ser_no_drive)
    else $error("device drove data in serial mode");
  property p_cmd_no_drive; $rose(devOe) |-> dc && !csN; endproperty
  a_cmd_no_drive: assert property (p_cmd_no_drive)
    else $error("device drove data on a command read");
  property p_m68_rd_held; devOe && xferClk && busMode == MODE_M68 |=> devOe; endproperty
  a_m68_rd_held: assert property (p_m68_rd_held)
    else $error("read data dropped while enable high");
  property p_m68_rd_release;
    $fell(xferClk) && devOe && busMode == MODE_M68 |-> ##[1:6] !devOe;
  endproperty
  a_m68_rd_release: assert property (p_m68_rd_release)
    else $error("read data not released after enable");
  property p_i80_rd_held; devOe && !dirRd && busMode == MODE_I80 |=> devOe; endproperty
  a_i80_rd_held: assert property (p_i80_rd_held)
    else $error("read data dropped while read strobe low");
  property p_i80_rd_release;
    $rose(dirRd) && devOe && busMode == MODE_I80 |-> ##[1:6] !devOe;
  endproperty
  a_i80_rd_release: assert property (p_i80_rd_release)
    else $error("read data not released after read strobe");
  property p_no_clash; !(hostOe && devOe); endproperty
  a_no_clash: assert property (p_no_clash)
    else $error("both ends drive the data bus");
  property p_m68_wr_setup;
    $fell(xferClk) && !csN && !dirRd && busMode == MODE_M68 |-> hostOe && $stable(hostData);
  endproperty
  a_m68_wr_setup: assert property (p_m68_wr_setup)
    else $error("write data not steady at enable fall");
  property p_i80_wr_setup;
    $rose(xferClk) && !csN && dirRd && busMode == MODE_I80 |-> hostOe && $stable(hostData);
  endproperty
  a_i80_wr_setup: assert property (p_i80_wr_setup)
    else $error("write data not steady at write strobe rise");
  property p_ser_setup; $fell(xferClk) && !csN && busMode[1] |-> $stable(sdata); endproperty
  a_ser_setup: assert property (p_ser_setup)
    else $error("serial data moved at clock fall");
endmodule

/* testbench/tb_top.sv */
// Testbench joining the LCD host controller to the LCD data port
module tb_top import lcd_link_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk, linkClk, rst_n, regWr, regRd, ramWe, cmdValid, oscExtSel, oscEnable;
  logic [7:0] regAddr, ramAddr, ramWrData, ramRdData, cmdByte;
  logic [31:0] regWrData, regRdData, rd;
  logic [7:0] mem [256];
  int miscompares, samples_checked, cycles, cmdCount, expCmd;

  lcd_link_if link();
  lcd_port_host i_lcd_port_host (.mclk(mclk), .rst_n(rst_n), .regAddr(regAddr),
    .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .link(link));
  lcd_port_device i_lcd_port_device (.linkClk(linkClk), .rst_n(rst_n), .link(link),
    .ramWe(ramWe), .ramAddr(ramAddr), .ramWrData(ramWrData), .ramRdData(ramRdData),
    .cmdValid(cmdValid), .cmdByte(cmdByte), .oscExtSel(oscExtSel), .oscEnable(oscEnable));
  lcd_link_props i_lcd_link_props (.linkClk(linkClk), .rst_n(rst_n), .busMode(link.busMode),
    .csN(link.csN), .dc(link.dc), .dirRd(link.dirRd), .xferClk(link.xferClk),
    .sdata(link.sdata), .hostData(link.hostData), .hostOe(link.hostOe), .devOe(link.devOe));

  // Clocks, the link one offset by 3 ns; every fifth link edge still meets an mclk edge
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  initial begin
    linkClk = 1'b0;
    #3;
    forever #16 linkClk = ~linkClk;
  end

  // RAM model answers the address at once; command pulses are counted
  assign ramRdData = mem[ramAddr];
  always @(posedge linkClk) begin
    if (ramWe) mem[ramAddr] <= ramWrData;
    if (cmdValid) cmdCount <= cmdCount + 1;
  end

  // Hang guard, well above the expected run length
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      miscompares++;
      finish_test();
    end
  end

  task automatic finish_test;
    $display("checks %0d, mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    regAddr <= a;
    regWrData <= d;
    regWr <= 1'b1;
    @(posedge mclk);
    regWr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rdr(input logic [7:0] a, output logic [31:0] d);
    @(posedge mclk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge mclk);
    regRd <= 1'b0;
    #1 d = regRdData;
  endtask

  task automatic idle;
    int n;
    n = 0;
    do begin
      rdr(REG_STAT, rd);
      n++;
    end while (rd[STAT_BUSY_BIT] !== 1'b0 && n < 3000);
    check(8'(rd[STAT_BUSY_BIT]), 8'h0);
  endtask

  task automatic xfer(input logic [1:0] m, input logic dcv, input logic [7:0] b);
    wr(REG_CTRL, 32'(m) | (32'(dcv) << CTRL_DC_BIT));
    idle();
    wr(REG_TX, 32'(b));
    idle();
    if (!dcv) expCmd++;
  endtask

  task automatic rdx(input logic [1:0] m, input logic dcv);
    wr(REG_CTRL, 32'(m) | (32'(dcv) << CTRL_DC_BIT));
    idle();
    wr(REG_RX, 32'h0);
    idle();
    rdr(REG_STAT, rd);
  endtask

  // Column MSB then the seven low bits
  task automatic setCol(input logic [1:0] m, input logic [7:0] c);
    xfer(m, 1'b0, c[7] ? 8'h27 : 8'h26);
    xfer(m, 1'b0, {1'b1, c[6:0]});
  endtask

  initial begin
    rst_n = 1'b0;
    regWr = 1'b0;
    regRd = 1'b0;
    regAddr = 8'h00;
    regWrData = 32'h0;
    {miscompares, samples_checked, cycles, cmdCount, expCmd} = '0;
    for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'h5a;
    // Reset spans slow-clock edges so the link side sees it too
    repeat (6) @(posedge linkClk);
    @(posedge mclk) rst_n <= 1'b1;
    repeat (4) @(posedge linkClk);
    check(8'(oscExtSel), 8'(OSC_EXT_RST));
    check(8'(oscEnable), 8'(OSC_EN_RST));
    check(ramAddr, COL_RST);
    rdr(8'h10, rd);
    check(rd[7:0] | rd[15:8] | rd[23:16] | rd[31:24], 8'h00);
    // Enable ahead of source select is refused and flagged once
    wr(REG_CTRL, 32'(MODE_M68));
    idle();
    wr(REG_TX, 32'h7f);
    rdr(REG_STAT, rd);
    check(8'(rd[STAT_REF_BIT]), 8'h1);
    rdr(REG_STAT, rd);
    check(8'(rd[STAT_REF_BIT]), 8'h0);
    check(8'(oscEnable), 8'h0);
    xfer(MODE_M68, 1'b0, 8'h7b);
    check(8'(oscExtSel), 8'h1);
    xfer(MODE_I80, 1'b0, 8'h7f);
    check(8'(oscEnable), 8'h1);
    xfer(MODE_SER, 1'b0, 8'h7a);
    check(8'(oscExtSel), 8'h0);
    xfer(MODE_I80, 1'b0, 8'h7e);
    check(8'(oscEnable), 8'h0);
    // Each bus writes across the last column; only the two parallel buses then read back
    for (int m = 0; m < 3; m++) begin
      setCol(2'(m), 8'hfe);
      check(ramAddr, 8'hfe);
      check(cmdByte, 8'hfe);
      xfer(2'(m), 1'b1, 8'h30 + 8'(m));
      check(ramAddr, 8'hff);
      xfer(2'(m), 1'b1, 8'hc0 + 8'(m));
      check(ramAddr, 8'h00);
      check(mem[8'hfe], 8'h30 + 8'(m));
      check(mem[8'hff], 8'hc0 + 8'(m));
      setCol(2'(m), 8'hfe);
      rdx(2'(m), 1'b1);
      if (m == 2) begin
        check(ramAddr, 8'hfe);
      end else begin
        check(rd[15:8], 8'h30 + 8'(m));
        check(ramAddr, 8'hff);
        setCol(2'(m), 8'hfe);
      end
    end
    rdx(MODE_I80, 1'b0);
    check(ramAddr, 8'hfe);
    // Dummy write after a clear leaves the pointer
    xfer(MODE_M68, 1'b0, 8'h36);
    xfer(MODE_M68, 1'b1, 8'h00);
    check(ramAddr, 8'hfe);
    xfer(MODE_M68, 1'b1, 8'h00);
    check(ramAddr, 8'hff);
    xfer(MODE_I80, 1'b0, 8'h37);
    xfer(MODE_SER, 1'b1, 8'h00);
    check(ramAddr, 8'hff);
    xfer(MODE_I80, 1'b0, 8'h7a);
    check(ramAddr, 8'hff);
    check(8'(cmdCount), 8'(expCmd));
    finish_test();
  end
endmodule
